// ### hw/phase_decoder.sv
/*
  Phase decoder: synchronises two phase inputs and turns them into one up or down step per clock.
  Assumes inputs asynchronous to clk_sys_i, pulses at least a few clock cycles wide.
*/
`timescale 1ns/100ps
module phase_decoder
  import pulse_timer_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  output logic step_up_o,
  output logic step_down_o
);

  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic last_a;
  logic last_b;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic a_lvl;
  logic b_lvl;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
      last_a <= 1'b0;
      last_b <= 1'b0;
    end else begin
      sync_a <= {sync_a[0], phase_a_i};
      sync_b <= {sync_b[0], phase_b_i};
      last_a <= sync_a[1];
      last_b <= sync_b[1];
    end
  end

  assign a_lvl = sync_a[1];
  assign b_lvl = sync_b[1];
  assign a_rise = a_lvl & ~last_a;
  assign a_fall = ~a_lvl & last_a;
  assign b_rise = b_lvl & ~last_b;
  assign b_fall = ~b_lvl & last_b;

  // Levels are the current samples, so simultaneous edges resolve to at most one step (none in mode 3 when A and B fall together).
  always_comb begin
    step_up_o = 1'b0;
    step_down_o = 1'b0;
    unique case (phase_mode_e'(mode_i))
      MODE_OFF: begin
      end
      MODE_PHASE2: begin
        step_up_o = a_fall & b_lvl;
        step_down_o = a_fall & ~b_lvl;
      end
      MODE_PHASE3: begin
        step_up_o = a_fall & b_lvl & ~b_fall;
        step_down_o = b_fall & a_lvl & ~a_fall;
      end
      MODE_PHASE4: begin
        step_up_o = (b_rise & a_lvl) | (b_fall & ~a_lvl);
        step_down_o = (b_fall & a_lvl) | (b_rise & ~a_lvl);
      end
    endcase
  end

endmodule : phase_decoder

// ### hw/pulse_timer_pkg.sv
/*
  Constants and types shared by the phase counter and the request logic of the pulse timer unit.
  Assumes a single 50 MHz system clock.
*/
package pulse_timer_pkg;

  localparam int CNT_W = 16;
  localparam int ADDR_W = 4;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

  // Register indices, one 16-bit register per address.
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN0 = 4'h1;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN1 = 4'h2;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN2 = 4'h3;
  localparam logic [ADDR_W-1:0] REG_STATUS0 = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS1 = 4'h5;
  localparam logic [ADDR_W-1:0] REG_STATUS2 = 4'h6;
  localparam logic [ADDR_W-1:0] REG_COUNT1 = 4'h7;
  localparam logic [ADDR_W-1:0] REG_COUNT2 = 4'h8;

  // Status and enable field positions (same in both register kinds).
  localparam int BIT_MATCH_A = 0;
  localparam int BIT_MATCH_B = 1;
  localparam int BIT_MATCH_C = 2;
  localparam int BIT_MATCH_D = 3;
  localparam int BIT_OVF = 4;
  localparam int BIT_UNF = 5;
  localparam int BIT_TRIG = 7;
  localparam int STAT_W = 6;

  // Control register: mode of channel 1 in bits 1:0, channel 2 in bits 3:2.
  localparam int CTRL_CH1_POS = 0;
  localparam int CTRL_CH2_POS = 2;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_PHASE2,
    MODE_PHASE3,
    MODE_PHASE4
  } phase_mode_e;

endpackage : pulse_timer_pkg

// ### hw/quadrature_count_and_irq.sv
/*
  Phase counters of channels 1 and 2 and the request logic of all three channels.
  Assumes a register port with one-cycle strobes and read data in the next cycle; match events
  of each compare register arrive as one-cycle pulses from the compare logic outside.
*/
// Strobed register access and the address map were chosen for this implementation.
// Function
// - Mode 2: A falling edge, direction from B.
// - Mode 3: up on A fall, down on B fall.
// - Mode 4: count on B edges, direction from A.
// - Three source classes, each flag and enable.
// - Event sets flag; request needs enable too.
// - Request drops when its flag or its enable clears.
// - Fixed priority inside channel, channel 0 first.
// - Eight capture or match requests.
// - One overflow request per channel.
// - Underflow requests on channels 1 and 2 only.
// - Only match requests activate transfer controller.
// - Flag A with trigger enable starts conversion.
// - Three conversion starts, one per channel.
// - Phase counting on channels 1, 2 pins.
// - Up wrap sets overflow, down wrap underflow.
// - Flag clears by read as 1, write 0.
// - Transfer activation clears its flag automatically.
`timescale 1ns/100ps
module quadrature_count_and_irq
  import pulse_timer_pkg::*;
#(
  parameter int NUM_CH = 3
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic ext_clock_pin_1_i,
  input wire logic ext_clock_pin_2_i,
  input wire logic ext_clock_pin_3_i,
  input wire logic ext_clock_pin_4_i,
  input wire logic [3:0] ch0_match_i,
  input wire logic [1:0] ch1_match_i,
  input wire logic [1:0] ch2_match_i,
  input wire logic [7:0] dtc_enable_i,
  input wire logic [7:0] dtc_ack_i,
  input wire logic [3:0] ch0_ovf_i,
  output logic [12:0] irq_req_o,
  output logic [7:0] dtc_req_o,
  output logic [2:0] adc_start_o
);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Registers and flags.

  logic [3:0] ctrl;
  logic [7:0] enable [NUM_CH];
  logic [STAT_W-1:0] status [NUM_CH];
  logic [STAT_W-1:0] seen_one [NUM_CH];
  logic [CNT_W-1:0] count [1:2];
  logic [STAT_W-1:0] set_ev [NUM_CH];
  logic [STAT_W-1:0] valid_src [NUM_CH];
  logic [STAT_W-1:0] dtc_clr [NUM_CH];
  logic [1:0] up;
  logic [1:0] down;

  // Channel 0 counter overflow comes from outside; this block counts only channels 1 and 2.
  assign valid_src[0] = 6'h1f;
  assign valid_src[1] = 6'h33;
  assign valid_src[2] = 6'h33;

  function automatic logic [ADDR_W-1:0] status_addr(input int ch);
    status_addr = REG_STATUS0 + ADDR_W'(ch);
  endfunction : status_addr

  function automatic logic [ADDR_W-1:0] enable_addr(input int ch);
    enable_addr = REG_IRQ_EN0 + ADDR_W'(ch);
  endfunction : enable_addr

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Phase counting on channels 1 and 2.

  phase_decoder u_dec1 (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .mode_i(ctrl[CTRL_CH1_POS +: 2]),
    .phase_a_i(ext_clock_pin_1_i),
    .phase_b_i(ext_clock_pin_2_i),
    .step_up_o(up[0]),
    .step_down_o(down[0])
  );

  phase_decoder u_dec2 (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .mode_i(ctrl[CTRL_CH2_POS +: 2]),
    .phase_a_i(ext_clock_pin_3_i),
    .phase_b_i(ext_clock_pin_4_i),
    .step_up_o(up[1]),
    .step_down_o(down[1])
  );

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      count[1] <= CNT_RESET;
      count[2] <= CNT_RESET;
    end else begin
      for (int c = 1; c <= 2; c++) begin
        if (up[c-1]) begin
          count[c] <= count[c] + 16'h0001;
        end else if (down[c-1]) begin
          count[c] <= count[c] - 16'h0001;
        end
      end
    end
  end

  property p_count_up;
    @(posedge clk_sys_i) disable iff (rst_i)
    up[0] |=> count[1] == $past(count[1]) + 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("channel 1 up step lost");
  property p_count_down;
    @(posedge clk_sys_i) disable iff (rst_i)
    down[1] |=> count[2] == $past(count[2]) - 16'h0001;
  endproperty
  a_count_down: assert property (p_count_down) else $error("channel 2 down step lost");
  property p_count_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
    (!up[0] && !down[0]) |=> count[1] == $past(count[1]);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("channel 1 moved without a step");
  property p_mode_off;
    @(posedge clk_sys_i) disable iff (rst_i)
    phase_mode_e'(ctrl[CTRL_CH2_POS +: 2]) == MODE_OFF |-> !up[1] && !down[1];
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("channel 2 stepped while off");

  // Event vectors: bit layout A, B, C, D, overflow, underflow.
  always_comb begin
    set_ev[0] = {1'b0, ch0_ovf_i[0], ch0_match_i};
    for (int c = 1; c <= 2; c++) begin
      set_ev[c] = '0;
      set_ev[c][BIT_OVF] = up[c-1] && (count[c] == CNT_MAX);
      set_ev[c][BIT_UNF] = down[c-1] && (count[c] == CNT_RESET);
    end
    set_ev[1][1:0] = ch1_match_i;
    set_ev[2][1:0] = ch2_match_i;
  end

  // Transfer controller clears the flag of the match source it serviced.
  always_comb begin
    dtc_clr[0] = {2'b00, dtc_ack_i[3:0]};
    dtc_clr[1] = {4'h0, dtc_ack_i[5:4]};
    dtc_clr[2] = {4'h0, dtc_ack_i[7:6]};
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register port.

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= 4'h0;
      for (int c = 0; c < NUM_CH; c++) begin
        enable[c] <= 8'h00;
      end
    end else if (wr_i) begin
      if (addr_i == REG_CTRL) begin
        ctrl <= wdata_i[3:0];
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (addr_i == enable_addr(c)) begin
          enable[c] <= wdata_i[7:0] & {1'b1, 1'b0, valid_src[c]};
        end
      end
    end
  end

  // Flags: event wins over clear; a write clear needs a prior read that saw the flag at 1.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        status[c] <= '0;
        seen_one[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        logic [STAT_W-1:0] clr;
        clr = dtc_clr[c];
        if (wr_i && addr_i == status_addr(c)) begin
          clr = clr | (seen_one[c] & ~wdata_i[STAT_W-1:0]);
          seen_one[c] <= '0;
        end else if (rd_i && addr_i == status_addr(c)) begin
          seen_one[c] <= status[c];
        end
        status[c] <= ((status[c] & ~clr) | set_ev[c]) & valid_src[c];
      end
    end
  end

  property p_seen_cleared;
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == REG_STATUS1) |=> seen_one[1] == '0;
  endproperty
  a_seen_cleared: assert property (p_seen_cleared) else $error("read permission outlived a write");

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      unique case (addr_i)
        REG_CTRL: rdata_o <= {12'h000, ctrl};
        REG_IRQ_EN0: rdata_o <= {8'h00, enable[0]};
        REG_IRQ_EN1: rdata_o <= {8'h00, enable[1]};
        REG_IRQ_EN2: rdata_o <= {8'h00, enable[2]};
        REG_STATUS0: rdata_o <= {10'h000, status[0]};
        REG_STATUS1: rdata_o <= {10'h000, status[1]};
        REG_STATUS2: rdata_o <= {10'h000, status[2]};
        REG_COUNT1: rdata_o <= count[1];
        REG_COUNT2: rdata_o <= count[2];
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Requests. Bit order of irq_req_o is the fixed priority order, bit 0 highest.

  logic [STAT_W-1:0] act [NUM_CH];
  logic [2:0] flag_a_d;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      act[c] = status[c] & enable[c][STAT_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_req_o <= 13'h0000;
      dtc_req_o <= 8'h00;
    end else begin
      irq_req_o <= {act[2][BIT_UNF], act[2][BIT_OVF], act[2][1:0],
                    act[1][BIT_UNF], act[1][BIT_OVF], act[1][1:0],
                    act[0][BIT_OVF], act[0][3:0]};
      // Match requests only; the routing mask picks those that go to the transfer controller.
      dtc_req_o <= {act[2][1:0], act[1][1:0], act[0][3:0]} & dtc_enable_i;
    end
  end

  property p_unf_req;
    @(posedge clk_sys_i) disable iff (rst_i)
    (status[2][BIT_UNF] && enable[2][BIT_UNF]) |=> irq_req_o[12];
  endproperty
  a_unf_req: assert property (p_unf_req) else $error("channel 2 underflow request missing");
  property p_irq_ovf0;
    @(posedge clk_sys_i) disable iff (rst_i)
    (status[0][BIT_OVF] && enable[0][BIT_OVF]) |=> irq_req_o[4];
  endproperty
  a_irq_ovf0: assert property (p_irq_ovf0) else $error("channel 0 overflow request missing");
  property p_dtc_gate;
    @(posedge clk_sys_i) disable iff (rst_i)
    !dtc_enable_i[0] |=> !dtc_req_o[0];
  endproperty
  a_dtc_gate: assert property (p_dtc_gate) else $error("transfer request not routed");
  property p_dtc_src;
    @(posedge clk_sys_i) disable iff (rst_i)
    dtc_req_o[0] |-> $past(status[0][BIT_MATCH_A]);
  endproperty
  a_dtc_src: assert property (p_dtc_src) else $error("transfer request without match flag");

  // A start pulse on the rising of flag A while the trigger enable is set.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      flag_a_d <= 3'h0;
      adc_start_o <= 3'h0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        flag_a_d[c] <= status[c][BIT_MATCH_A];
        adc_start_o[c] <= status[c][BIT_MATCH_A] & ~flag_a_d[c] & enable[c][BIT_TRIG];
      end
    end
  end

  property p_adc_pulse;
    @(posedge clk_sys_i) disable iff (rst_i)
    adc_start_o[0] |=> !adc_start_o[0];
  endproperty
  a_adc_pulse: assert property (p_adc_pulse) else $error("start request longer than one cycle");

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_ovf_flag;
    @(posedge clk_sys_i) disable iff (rst_i)
    (up[0] && count[1] == CNT_MAX) |=> status[1][BIT_OVF] && count[1] == CNT_RESET;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set on up wrap");
  property p_unf_flag;
    @(posedge clk_sys_i) disable iff (rst_i)
    (down[1] && count[2] == CNT_RESET) |=> status[2][BIT_UNF] && count[2] == CNT_MAX;
  endproperty
  a_unf_flag: assert property (p_unf_flag) else $error("underflow flag not set on down wrap");
  property p_irq_follows;
    @(posedge clk_sys_i) disable iff (rst_i)
    1 |=> irq_req_o[0] == $past(status[0][0] & enable[0][0]);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("request not flag and enable");
  property p_held;
    @(posedge clk_sys_i) disable iff (rst_i)
    (status[1][BIT_OVF] && enable[1][BIT_OVF]) |=> irq_req_o[7];
  endproperty
  a_held: assert property (p_held) else $error("request dropped while flag set");
  property p_no_ch0_unf;
    @(posedge clk_sys_i) disable iff (rst_i) !status[0][BIT_UNF];
  endproperty
  a_no_ch0_unf: assert property (p_no_ch0_unf) else $error("channel 0 underflow flag set");
  property p_clear_needs_read;
    @(posedge clk_sys_i) disable iff (rst_i)
    (status[0][0] && !seen_one[0][0] && dtc_ack_i[0] == 1'b0 && !ch0_match_i[0]) |=> status[0][0];
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read) else $error("flag cleared without read");
  property p_one_step;
    @(posedge clk_sys_i) disable iff (rst_i) !(up[0] && down[0]) && !(up[1] && down[1]);
  endproperty
  a_one_step: assert property (p_one_step) else $error("two steps in one cycle");
  property p_adc;
    @(posedge clk_sys_i) disable iff (rst_i)
    adc_start_o[1] |-> $past(status[1][BIT_MATCH_A]) && $past(enable[1][BIT_TRIG]);
  endproperty
  a_adc: assert property (p_adc) else $error("start without flag A and enable");
  property p_dtc_clear;
    @(posedge clk_sys_i) disable iff (rst_i) (dtc_ack_i[4] && !ch1_match_i[0]) |=> !status[1][0];
  endproperty
  a_dtc_clear: assert property (p_dtc_clear) else $error("transfer did not clear flag");

  c_wrap_up: cover property (@(posedge clk_sys_i) up[0] && count[1] == CNT_MAX);
  c_wrap_down: cover property (@(posedge clk_sys_i) down[1] && count[2] == CNT_RESET);
  c_adc: cover property (@(posedge clk_sys_i) adc_start_o != 3'h0);
  c_dtc_ack: cover property (@(posedge clk_sys_i) dtc_ack_i != 8'h00);
  c_sw_clear: cover property (@(posedge clk_sys_i) wr_i && addr_i == REG_STATUS0 && seen_one[0] != '0);

endmodule : quadrature_count_and_irq

// ### verif/irq_partner_model.sv
/*
  Model of the transfer controller and the A/D converter beyond the request outputs.
  Assumes request levels and start pulses from the timer on the same clock.
*/
`timescale 1ns/100ps
module irq_partner_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] dtc_req_i,
  input wire logic [2:0] adc_start_i,
  input wire logic timer_trig_sel_i,
  input wire logic [3:0] ack_delay_i,
  output logic [7:0] dtc_ack_o,
  output logic [7:0] conv_count_o
);
  logic [1:0] state;
  logic [2:0] src;
  logic [3:0] wait_cnt;

  // Serves the lowest pending source, then waits until its request drops.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= 2'h0;
      src <= 3'h0;
      wait_cnt <= 4'h0;
      dtc_ack_o <= 8'h00;
    end else if (state == 2'h0) begin
      if (|dtc_req_i) begin
        for (int i = 7; i >= 0; i--) begin
          if (dtc_req_i[i]) src <= 3'(i);
        end
        wait_cnt <= ack_delay_i;
        state <= 2'h1;
      end
    end else if (state == 2'h1) begin
      if (wait_cnt == 4'h0) begin
        dtc_ack_o[src] <= 1'b1;
        state <= 2'h2;
      end else begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end else begin
      dtc_ack_o <= 8'h00;
      if (!dtc_req_i[src]) state <= 2'h0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      conv_count_o <= 8'h00;
    end else if (timer_trig_sel_i) begin
      conv_count_o <= conv_count_o + 8'($countones(adc_start_i));
    end
  end
endmodule : irq_partner_model

// ### verif/test_quadrature_count_and_irq.sv
/*
  Self-checking bench for the phase counters and the request logic.
  Assumes irq_partner_model on the request outputs and a 50 MHz clock.
*/
`timescale 1ns/100ps
module test_quadrature_count_and_irq
  import pulse_timer_pkg::*;
;
  logic clk, rst, wr, rd, p1, p2, p3, p4, sel;
  logic [ADDR_W-1:0] addr;
  logic [15:0] wdata, rdata, rv, cnt1, cnt2, st1, st2;
  logic [3:0] m0, ovf0, delay;
  logic [1:0] m1, m2;
  logic [7:0] dtc_en, dtc_ack, dtc_req, conv, q;
  logic [12:0] irq;
  logic [2:0] adc;
  int failures, samples_checked;

  quadrature_count_and_irq DUT (.clk_sys_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_clock_pin_1_i(p1), .ext_clock_pin_2_i(p2),
    .ext_clock_pin_3_i(p3), .ext_clock_pin_4_i(p4), .ch0_match_i(m0), .ch1_match_i(m1),
    .ch2_match_i(m2), .dtc_enable_i(dtc_en), .dtc_ack_i(dtc_ack), .ch0_ovf_i(ovf0),
    .irq_req_o(irq), .dtc_req_o(dtc_req), .adc_start_o(adc));
  irq_partner_model partner (.clk_sys_i(clk), .rst_i(rst), .dtc_req_i(dtc_req),
    .adc_start_i(adc), .timer_trig_sel_i(sel), .ack_delay_i(delay), .dtc_ack_o(dtc_ack),
    .conv_count_o(conv));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_check

  // Reads each of the three status registers without a check, then writes zero to clear the flags seen at 1.
  task automatic clear_all();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      addr <= ADDR_W'(REG_STATUS0 + i);
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      wr_reg(ADDR_W'(REG_STATUS0 + i), 16'h0000);
    end
  endtask : clear_all

  task automatic pulse(input logic [3:0] a, input logic [1:0] b, input logic [3:0] o);
    @(posedge clk);
    m0 <= a;
    m1 <= b;
    m2 <= b;
    ovf0 <= o;
    @(posedge clk);
    m0 <= 4'h0;
    m1 <= 2'h0;
    m2 <= 2'h0;
    ovf0 <= 4'h0;
    repeat (4) @(posedge clk);
  endtask : pulse

  function automatic int exp_step(phase_mode_e m, logic pa, logic pb, logic na, logic nb);
    if (m == MODE_PHASE2 && pa && !na) return nb ? 1 : -1;
    if (m == MODE_PHASE3 && pa && !na && nb) return 1;
    if (m == MODE_PHASE3 && pb && !nb && na) return -1;
    if (m == MODE_PHASE4 && pb != nb) return (nb == na) ? 1 : -1;
    return 0;
  endfunction : exp_step

  task automatic advance(inout logic [15:0] c, inout logic [15:0] st, input int s);
    if (s > 0 && c == 16'hffff) st[BIT_OVF] = 1'b1;
    if (s < 0 && c == 16'h0000) st[BIT_UNF] = 1'b1;
    c = c + 16'(s);
  endtask : advance

  // Channel 2 sees the same waveform with its phases swapped, so it runs the other way on steps where only one phase switches.
  task automatic move(input phase_mode_e m, input logic na, input logic nb);
    advance(cnt1, st1, exp_step(m, p1, p2, na, nb));
    advance(cnt2, st2, exp_step(m, p3, p4, nb, na));
    @(posedge clk);
    p1 <= na;
    p2 <= nb;
    p3 <= nb;
    p4 <= na;
    repeat (6) @(posedge clk);
  endtask : move

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end

  initial begin
    {rst, sel, wr, rd, p1, p2, p3, p4} = 8'hc0;
    {addr, wdata, m0, m1, m2, ovf0, dtc_en, delay} = '0;
    {cnt1, cnt2, st1, st2} = '0;
    failures = 0;
    samples_checked = 0;
    delay = 4'h8;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_check(REG_STATUS0, 16'h0000);
    rd_check(4'hf, 16'h0000);
    wr_reg(REG_IRQ_EN1, 16'h0030);
    wr_reg(REG_IRQ_EN2, 16'h0030);
    for (int m = 1; m < 4; m++) begin
      wr_reg(REG_CTRL, 16'(m) | 16'(m << CTRL_CH2_POS));
      for (int r = 0; r < 3; r++) begin
        q = (r == 0) ? 8'b01_11_10_00 : 8'b10_11_01_00;
        for (int k = 0; k < 4; k++) move(phase_mode_e'(m), q[7 - 2 * k], q[6 - 2 * k]);
      end
      // Both phases switch in the same cycle, up and then down again.
      move(phase_mode_e'(m), 1'b1, 1'b1);
      move(phase_mode_e'(m), 1'b0, 1'b0);
      rd_check(REG_COUNT1, cnt1);
      rd_check(REG_COUNT2, cnt2);
      rd_check(REG_STATUS1, st1);
      rd_check(REG_STATUS2, st2);
      rv = {12'h000, st2[BIT_UNF], st2[BIT_OVF], st1[BIT_UNF], st1[BIT_OVF]};
      check({12'h000, irq[12:11], irq[8:7]}, rv);
      wr_reg(REG_STATUS1, 16'h0000);
      wr_reg(REG_STATUS2, 16'h0000);
      {st1, st2} = '0;
      rd_check(REG_STATUS1, 16'h0000);
      check({12'h000, irq[12:11], irq[8:7]}, 16'h0000);
    end
    wr_reg(REG_CTRL, 16'h0000);
    wr_reg(REG_IRQ_EN0, 16'h00bf);
    wr_reg(REG_IRQ_EN1, 16'h00bf);
    wr_reg(REG_IRQ_EN2, 16'h00bf);
    rd_check(REG_IRQ_EN0, 16'h009f);
    rd_check(REG_IRQ_EN1, 16'h00b3);
    pulse(4'hf, 2'h3, 4'h1);
    check({3'h0, irq}, 16'h067f);
    check({8'h0, conv}, 16'h0003);
    wr_reg(REG_IRQ_EN0, 16'h0080);
    repeat (2) @(posedge clk);
    #1;
    check({3'h0, irq}, 16'h0660);
    wr_reg(REG_IRQ_EN0, 16'h00bf);
    wr_reg(REG_STATUS0, 16'h0000);
    rd_check(REG_STATUS0, 16'h001f);
    wr_reg(REG_STATUS0, 16'h001e);
    repeat (2) @(posedge clk);
    #1;
    check({3'h0, irq}, 16'h067e);
    clear_all();
    repeat (2) @(posedge clk);
    #1;
    check({3'h0, irq}, 16'h0000);
    @(posedge clk);
    sel <= 1'b0;
    pulse(4'h1, 2'h1, 4'h0);
    check({8'h0, conv}, 16'h0003);
    clear_all();
    sel <= 1'b1;
    dtc_en <= 8'hff;
    pulse(4'hf, 2'h3, 4'h1);
    check({8'h0, dtc_req}, 16'h00ff);
    check({8'h0, conv}, 16'h0006);
    repeat (150) @(posedge clk);
    check({8'h0, dtc_req}, 16'h0000);
    rd_check(REG_STATUS0, 16'h0010);
    delay <= 4'h0;
    pulse(4'h0, 2'h3, 4'h0);
    repeat (60) @(posedge clk);
    rd_check(REG_STATUS1, 16'h0000);
    check({3'h0, irq}, 16'h0010);
    report_and_stop();
  end
endmodule : test_quadrature_count_and_irq
